/* verilog/flash_defines.svh */
/*
   constants of the flash protection and status block: register byte addresses,
   field positions, reset values, command codes, flash layout and timing counts.
   assumes a 20 MHz system clock and 16-bit flash words.

*/
`ifndef FLASH_DEFINES_SVH
`define FLASH_DEFINES_SVH

`define STATUS_ADDR 32'hFFFF_F800
`define MODE_ADDR 32'hFFFF_F804
`define COMMAND_ADDR 32'hFFFF_F808
`define DATA_ADDR 32'hFFFF_F80C
`define ADDRESS_ADDR 32'hFFFF_F810
`define PERSIST_ADDR 32'hFFFF_F81C
`define VOLATILE_ADDR 32'hFFFF_F820

`define ST_PASS 0
`define ST_FAIL 1
`define ST_BUSY 2
`define ST_IRQ 3
`define STATUS_RESET 8'h20

`define MODE_FLASH_EN 3
`define MODE_IRQ_EN 4
`define MODE_KEY_LOW 5
`define MODE_KEY_EN 6

`define MODE_RESET 16'h0000
`define COMMAND_RESET 8'h07
`define PERSIST_RESET 32'h0000_0000
`define VOLATILE_RESET 32'hFFFF_FFFF
`define ERASED_WORD 16'hFFFF
`define ERASED_KEY 32'hFFFF_FFFF
`define PERMANENT_KEY 32'hDEAD_DEAD
`define READ_PROT_BIT 31

`define CMD_NULL 8'h00
`define CMD_READ 8'h01
`define CMD_WRITE 8'h02
`define CMD_ERASE_WRITE 8'h03
`define CMD_VERIFY 8'h04
`define CMD_ERASE 8'h05
`define CMD_MASS_ERASE 8'h06
`define CMD_PROTECT 8'h0C
`define CMD_PING 8'h0F

`define FLASH_WORDS 32768
`define USER_WORDS 15'h7C00
`define NV_LAST 15'h7C03
`define BOOT_WORD 15'h000A
`define REGION_SHIFT 10

`define CLK_MHZ 20
`define WRITE_TIME_US 50
`define ERASE_TIME_MS 24
`define MASS_TIME_MS 2480
`define WRITE_CYCLES (`WRITE_TIME_US * `CLK_MHZ)
`define ERASE_CYCLES (`ERASE_TIME_MS * 1000 * `CLK_MHZ)
`define MASS_CYCLES (`MASS_TIME_MS * 1000 * `CLK_MHZ)

`endif

/* verilog/flash_pkg.sv */
/*
   types of the flash protection and status block.
   assumes nothing beyond the constants header.
*/
package flash_pkg;
   typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_READ, ST_EXEC, ST_DBG} state_type;
   typedef struct packed {
      logic [31:0] key;
      logic [31:0] prot;
   } nv_image_type;
   typedef struct packed {
      logic irq;
      logic fail;
      logic pass;
   } flags_type;
endpackage

/* verilog/flash_mem.sv */
/*
   flash array model: one write port, one read port with registered data.
   assumes the sequencer never writes and reads the same word in one cycle.
*/
`timescale 1ns/10ps
module flash_mem #(
   parameter int unsigned DEPTH = 32768,
   parameter int unsigned WIDTH = 16
) (
   // clock
   input wire logic clk,
   // write port
   input wire logic we,
   input wire logic [$clog2(DEPTH)-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   // read port
   input wire logic [$clog2(DEPTH)-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] cells [DEPTH];

   // a fresh part is fully erased
   initial begin
      for (int i = 0; i < DEPTH; i++) begin
         cells[i] = '1;
      end
   end

   always_ff @(posedge clk) begin
      if (we) begin
         cells[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk) begin
      rdata <= cells[raddr];
   end
endmodule

/* verilog/protect_check.sv */
/*
   protection decode: write permission of one flash word and read permission.
   assumes protection bits are active low, erased ones meaning unprotected.
*/
`timescale 1ns/10ps
`include "flash_defines.svh"
module protect_check (
   // effective protection and word index
   input wire logic [31:0] prot,
   input wire logic [14:0] word,
   // permissions
   output logic write_ok,
   output logic read_ok
);
   logic [4:0] region;

   // four pages, 1024 words, per bit; kernel words are never writable
   assign region = word[14:`REGION_SHIFT];
   assign write_ok = (word < `USER_WORDS) && prot[region];
   assign read_ok = prot[`READ_PROT_BIT];
endmodule

/* verilog/flash_protect_status.sv */
/*
   flash control block: boot mode check, volatile and key-guarded persistent
   protection, command sequencer and clear-on-read status, behind an AXI4-Lite slave.
   assumes a single 20 MHz clock, synchronous active-low reset, and that software
   leaves the address and data registers alone while a command runs.
*/
`timescale 1ns/10ps
`include "flash_defines.svh"
module flash_protect_status #(
   parameter int unsigned ERASE_CYCLES = `ERASE_CYCLES,
   parameter int unsigned MASS_CYCLES = `MASS_CYCLES
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi write address
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   // axi write data
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi read address
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   // axi read data
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // boot strap
   input wire logic boot_select_pin,
   // debug read path
   input wire logic dbg_rd_req,
   input wire logic [15:0] dbg_rd_addr,
   output logic dbg_rd_valid,
   output logic [15:0] dbg_rd_data,
   output logic dbg_rd_denied,
   // status outputs
   output logic download_mode,
   output logic read_protect_active
);
   flash_pkg::state_type state;
   flash_pkg::nv_image_type nv;
   flash_pkg::flags_type flags;
   logic [15:0] flash_mode;
   logic [15:0] flash_address_reg;
   logic [15:0] flash_data_reg;
   logic [7:0] flash_command_reg;
   logic [31:0] persistent_protect_reg;
   logic [31:0] volatile_protect_reg;
   logic prot_done;
   logic [2:0] boot_step;
   logic [31:0] boot_word;
   logic [7:0] op;
   logic walk_on;
   logic [14:0] walk_idx;
   logic [14:0] walk_last;
   logic [25:0] delay;
   logic done_ok;
   logic done_bad;
   logic dbg_pending;
   logic [14:0] dbg_word;
   logic [31:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic [31:0] read_value;
   logic [14:0] mem_raddr;
   logic [15:0] mem_rdata;
   logic [15:0] walk_value;
   logic [31:0] eff_prot;
   logic [14:0] target;
   logic write_ok;
   logic read_ok;
   logic write_go;
   logic cmd_wr;
   logic [7:0] cmd_code;
   logic status_read;
   logic busy;
   logic key_saved;
   logic permanent;
   logic key_ok;
   logic exec_finish;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = data[8*b +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic mapped(input logic [31:0] a);
      return (a == `STATUS_ADDR) || (a == `MODE_ADDR) || (a == `COMMAND_ADDR) ||
             (a == `DATA_ADDR) || (a == `ADDRESS_ADDR) || (a == `PERSIST_ADDR) ||
             (a == `VOLATILE_ADDR);
   endfunction

   // both stores must allow the write; either one can protect
   assign eff_prot = nv.prot & volatile_protect_reg;
   assign target = flash_address_reg[15:1];
   assign write_go = !awready && !wready && !bvalid;
   assign cmd_wr = write_go && (aw_addr_q == `COMMAND_ADDR) && w_strb_q[0];
   assign cmd_code = w_data_q[7:0];
   assign status_read = arvalid && arready && (araddr == `STATUS_ADDR);
   assign busy = (state == flash_pkg::ST_READ) || (state == flash_pkg::ST_EXEC);
   assign key_saved = nv.key != `ERASED_KEY;
   assign permanent = nv.key == `PERMANENT_KEY;
   // software sets key enable with the lower bit clear and loads the key first
   assign key_ok = flash_mode[`MODE_KEY_EN] && !flash_mode[`MODE_KEY_LOW] && !prot_done &&
                   (!key_saved || (!permanent && ({flash_address_reg, flash_data_reg} == nv.key)));
   assign exec_finish = (state == flash_pkg::ST_EXEC) && !walk_on && (delay == 26'h000_0000);

   protect_check protect_check_i (
      .prot(eff_prot),
      .word(target),
      .write_ok(write_ok),
      .read_ok(read_ok)
   );

   flash_mem #(
      .DEPTH(`FLASH_WORDS),
      .WIDTH(16)
   ) flash_mem_i (
      .clk(aclk),
      .we((state == flash_pkg::ST_EXEC) && walk_on),
      .waddr(walk_idx),
      .wdata(walk_value),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );

   always_comb begin
      mem_raddr = target;
      if (state == flash_pkg::ST_BOOT) begin
         if (boot_step < 3'd2) begin
            mem_raddr = `BOOT_WORD + 15'(boot_step);
         end else begin
            mem_raddr = `USER_WORDS + 15'(boot_step - 3'd2);
         end
      end else if (!cmd_wr) begin
         mem_raddr = dbg_word;
      end
   end

   always_comb begin
      walk_value = `ERASED_WORD;
      case (op)
         `CMD_WRITE: walk_value = flash_data_reg;
         `CMD_ERASE_WRITE: walk_value = (walk_idx == target) ? flash_data_reg : `ERASED_WORD;
         `CMD_PROTECT: begin
            case (walk_idx[1:0])
               2'd0: walk_value = persistent_protect_reg[15:0];
               2'd1: walk_value = persistent_protect_reg[31:16];
               2'd2: walk_value = flash_data_reg;
               default: walk_value = flash_address_reg;
            endcase
         end
         default: walk_value = `ERASED_WORD;
      endcase
   end

   // sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= flash_pkg::ST_BOOT;
         boot_step <= 3'd0;
         op <= `CMD_NULL;
         walk_on <= 1'b0;
         walk_idx <= 15'h0000;
         walk_last <= 15'h0000;
         delay <= 26'h000_0000;
         done_ok <= 1'b0;
         done_bad <= 1'b0;
         prot_done <= 1'b0;
      end else begin
         done_ok <= 1'b0;
         done_bad <= 1'b0;
         case (state)
            flash_pkg::ST_BOOT: begin
               boot_step <= boot_step + 3'd1;
               if (boot_step == 3'd6) begin
                  state <= flash_pkg::ST_IDLE;
               end
            end
            flash_pkg::ST_IDLE: begin
               if (cmd_wr) begin
                  op <= cmd_code;
                  walk_idx <= {target[14:8], 8'h00};
                  walk_last <= {target[14:8], 8'hFF};
                  case (cmd_code)
                     `CMD_NULL: ;
                     `CMD_READ, `CMD_VERIFY: state <= flash_pkg::ST_READ;
                     `CMD_WRITE: begin
                        walk_idx <= target;
                        walk_last <= target;
                        delay <= 26'(`WRITE_CYCLES - 1);
                        walk_on <= flash_mode[`MODE_FLASH_EN] && write_ok;
                        state <= (flash_mode[`MODE_FLASH_EN] && write_ok) ? flash_pkg::ST_EXEC : state;
                        done_bad <= !(flash_mode[`MODE_FLASH_EN] && write_ok);
                     end
                     `CMD_ERASE, `CMD_ERASE_WRITE: begin
                        delay <= 26'(ERASE_CYCLES - 1);
                        walk_on <= flash_mode[`MODE_FLASH_EN] && write_ok;
                        state <= (flash_mode[`MODE_FLASH_EN] && write_ok) ? flash_pkg::ST_EXEC : state;
                        done_bad <= !(flash_mode[`MODE_FLASH_EN] && write_ok);
                     end
                     `CMD_MASS_ERASE: begin
                        // ignores protection: the only way out of permanent protection
                        walk_idx <= 15'h0000;
                        walk_last <= `NV_LAST;
                        delay <= 26'(MASS_CYCLES - 1);
                        walk_on <= flash_mode[`MODE_FLASH_EN];
                        state <= flash_mode[`MODE_FLASH_EN] ? flash_pkg::ST_EXEC : state;
                        done_bad <= !flash_mode[`MODE_FLASH_EN];
                     end
                     `CMD_PROTECT: begin
                        walk_idx <= `USER_WORDS;
                        walk_last <= `NV_LAST;
                        delay <= 26'(`WRITE_CYCLES - 1);
                        walk_on <= key_ok;
                        state <= key_ok ? flash_pkg::ST_EXEC : state;
                        done_bad <= !key_ok;
                     end
                     `CMD_PING: begin
                        delay <= 26'h000_0000;
                        state <= flash_pkg::ST_EXEC;
                     end
                     default: done_bad <= 1'b1;
                  endcase
               end else if (dbg_pending && read_ok) begin
                  state <= flash_pkg::ST_DBG;
               end
            end
            flash_pkg::ST_READ: begin
               state <= flash_pkg::ST_IDLE;
               if ((op == `CMD_VERIFY) && (mem_rdata != flash_data_reg)) begin
                  done_bad <= 1'b1;
               end else begin
                  done_ok <= 1'b1;
               end
            end
            flash_pkg::ST_EXEC: begin
               if (walk_on) begin
                  if (walk_idx == walk_last) begin
                     walk_on <= 1'b0;
                  end else begin
                     walk_idx <= walk_idx + 15'h0001;
                  end
               end
               if (delay != 26'h000_0000) begin
                  delay <= delay - 26'h000_0001;
               end
               if (exec_finish) begin
                  state <= flash_pkg::ST_IDLE;
                  done_ok <= 1'b1;
                  if (op == `CMD_PROTECT) begin
                     prot_done <= 1'b1;
                  end
               end
            end
            flash_pkg::ST_DBG: state <= flash_pkg::ST_IDLE;
            default: state <= flash_pkg::ST_IDLE;
         endcase
      end
   end

   // saved image is loaded at boot and set to erased by a mass erase, so a new save waits for the next reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         nv <= '1;
         boot_word <= `ERASED_KEY;
      end else if (state == flash_pkg::ST_BOOT) begin
         case (boot_step)
            3'd1: boot_word[15:0] <= mem_rdata;
            3'd2: boot_word[31:16] <= mem_rdata;
            3'd3: nv.prot[15:0] <= mem_rdata;
            3'd4: nv.prot[31:16] <= mem_rdata;
            3'd5: nv.key[15:0] <= mem_rdata;
            3'd6: nv.key[31:16] <= mem_rdata;
            default: ;
         endcase
      end else if (exec_finish && (op == `CMD_MASS_ERASE)) begin
         nv <= '1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         download_mode <= 1'b0;
      end else if ((state == flash_pkg::ST_BOOT) && (boot_step == 3'd6)) begin
         download_mode <= !boot_select_pin && (boot_word == `ERASED_KEY);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         read_protect_active <= 1'b0;
      end else begin
         read_protect_active <= !read_ok;
      end
   end

   // set wins over the clear of a status read in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags <= '0;
      end else begin
         flags.pass <= done_ok || (flags.pass && !status_read);
         flags.fail <= done_bad || (flags.fail && !status_read);
         flags.irq <= ((done_ok || done_bad) && flash_mode[`MODE_IRQ_EN]) ||
                      (flags.irq && !status_read);
      end
   end

   // software registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flash_mode <= `MODE_RESET;
      end else if (write_go && (aw_addr_q == `MODE_ADDR)) begin
         flash_mode <= 16'(merge({16'h0000, flash_mode}, w_data_q, w_strb_q));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flash_address_reg <= 16'h0000;
      end else if (write_go && (aw_addr_q == `ADDRESS_ADDR)) begin
         flash_address_reg <= 16'(merge({16'h0000, flash_address_reg}, w_data_q, w_strb_q));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flash_data_reg <= 16'h0000;
      end else if ((state == flash_pkg::ST_READ) && (op == `CMD_READ)) begin
         flash_data_reg <= mem_rdata;
      end else if (write_go && (aw_addr_q == `DATA_ADDR)) begin
         flash_data_reg <= 16'(merge({16'h0000, flash_data_reg}, w_data_q, w_strb_q));
      end
   end

   // commands written while busy are dropped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flash_command_reg <= `COMMAND_RESET;
      end else if (cmd_wr && (state == flash_pkg::ST_IDLE)) begin
         flash_command_reg <= ((cmd_code >= `CMD_READ) && (cmd_code <= `CMD_MASS_ERASE)) ?
                              `COMMAND_RESET : cmd_code;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         persistent_protect_reg <= `PERSIST_RESET;
      end else if (write_go && (aw_addr_q == `PERSIST_ADDR)) begin
         persistent_protect_reg <= merge(persistent_protect_reg, w_data_q, w_strb_q);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         volatile_protect_reg <= `VOLATILE_RESET;
      end else if (write_go && (aw_addr_q == `VOLATILE_ADDR)) begin
         volatile_protect_reg <= merge(volatile_protect_reg, w_data_q, w_strb_q);
      end
   end

   // debug read path: one request pending, served only between commands
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dbg_pending <= 1'b0;
         dbg_word <= 15'h0000;
         dbg_rd_valid <= 1'b0;
         dbg_rd_data <= 16'h0000;
         dbg_rd_denied <= 1'b0;
      end else begin
         dbg_rd_valid <= 1'b0;
         dbg_rd_denied <= 1'b0;
         if (dbg_rd_req && !dbg_pending) begin
            dbg_pending <= 1'b1;
            dbg_word <= dbg_rd_addr[15:1];
         end
         if ((state == flash_pkg::ST_IDLE) && !cmd_wr && dbg_pending && !read_ok) begin
            dbg_pending <= 1'b0;
            dbg_rd_denied <= 1'b1;
         end
         if (state == flash_pkg::ST_DBG) begin
            dbg_pending <= 1'b0;
            dbg_rd_valid <= 1'b1;
            dbg_rd_data <= mem_rdata;
         end
      end
   end

   // axi write channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= 2'b00;
         aw_addr_q <= 32'h0000_0000;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            aw_addr_q <= awaddr;
         end
         if (wvalid && wready) begin
            wready <= 1'b0;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
         if (write_go) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b1;
            bresp <= mapped(aw_addr_q) ? 2'b00 : 2'b10;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_comb begin
      read_value = 32'h0000_0000;
      case (araddr)
         `STATUS_ADDR: read_value = {24'h00_0000, `STATUS_RESET | {4'h0, flags.irq, busy, flags.fail, flags.pass}};
         `MODE_ADDR: read_value = {16'h0000, flash_mode};
         `COMMAND_ADDR: read_value = {24'h00_0000, flash_command_reg};
         `DATA_ADDR: read_value = {16'h0000, flash_data_reg};
         `ADDRESS_ADDR: read_value = {16'h0000, flash_address_reg};
         `PERSIST_ADDR: read_value = persistent_protect_reg;
         `VOLATILE_ADDR: read_value = volatile_protect_reg;
         default: read_value = 32'h0000_0000;
      endcase
   end

   // axi read channels
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= 2'b00;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= read_value;
         rresp <= mapped(araddr) ? 2'b00 : 2'b10;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end
endmodule

/* verification/flash_protect_status_chk.sv */
/* assertions on the ports of flash_protect_status.
   assumes the defines header and a bind onto the top module. */
`timescale 1ns/10ps
`include "flash_defines.svh"
module flash_protect_status_chk (
   // clock, reset and axi
   input wire logic aclk, aresetn, arvalid, arready, rvalid, rready, bvalid, bready,
   input wire logic [31:0] araddr, rdata,
   // debug read path
   input wire logic dbg_rd_valid, dbg_rd_denied, read_protect_active
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic st;
   // marks a pending read of the status register
   always_ff @(posedge aclk) begin
      if (!aresetn) st <= 0;
      else if (arvalid && arready) st <= araddr == `STATUS_ADDR;
   end
   property p_den; dbg_rd_denied |-> read_protect_active && !dbg_rd_valid; endproperty
   a_den: assert property (p_den) else $error("denied while open");
   property p_val; dbg_rd_valid |-> !read_protect_active ##1 !dbg_rd_valid; endproperty
   a_val: assert property (p_val) else $error("read served while protected");
   property p_dp; dbg_rd_denied |=> !dbg_rd_denied; endproperty
   a_dp: assert property (p_dp) else $error("denial longer than a pulse");
   property p_irq; rvalid && st && rdata[3] |-> rdata[1:0] != 2'h0; endproperty
   a_irq: assert property (p_irq) else $error("irq without pass or fail");
   property p_fix; rvalid && st |-> rdata[31:4] == 28'h2; endproperty
   a_fix: assert property (p_fix) else $error("status fixed bits wrong");
   property p_rv; rvalid && rready |=> !rvalid && arready; endproperty
   a_rv: assert property (p_rv) else $error("read answer not released");
   property p_bv; bvalid && bready |=> !bvalid; endproperty
   a_bv: assert property (p_bv) else $error("write answer not released");
   property p_ar; arvalid && arready |=> rvalid && !arready; endproperty
   a_ar: assert property (p_ar) else $error("read not answered");
endmodule
bind flash_protect_status flash_protect_status_chk flash_protect_status_chk_i (.*);

/* verification/flash_protect_status_bench.sv */
/* self-checking bench of flash_protect_status: axi tasks, commands, protection.
   assumes the defines header and an erased flash array at start. */
`timescale 1ns/10ps
`include "flash_defines.svh"
module flash_protect_status_bench;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic boot_select_pin = 0, dbg_rd_req = 0, awready, wready, bvalid, arready, rvalid;
   logic dbg_rd_valid, dbg_rd_denied, download_mode, read_protect_active;
   logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, a, d;
   logic [15:0] dbg_rd_addr = 0, dbg_rd_data, v;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] bresp, rresp, r;
   int fail_count = 0, total_checks = 0, n, p;
   always #25 aclk = ~aclk;
   // short erase counts keep the run brief
   flash_protect_status #(.ERASE_CYCLES(20), .MASS_CYCLES(40)) flash_protect_status_i (.*);
   task automatic chk(logic [31:0] g, e);
      total_checks++;
      if (g !== e) $display("wrong value at %0t: got %h, expected %h", $time, g, e);
      fail_count += (g !== e);
   endtask
   task automatic end_sim(int k);
      fail_count += k;
      if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic ax(logic w, logic [31:0] ad, v);
      @(posedge aclk);
      {awaddr, araddr, wdata} <= {ad, ad, v};
      {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
      n = 0;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         if (arready) arvalid <= 0;
         if (n++ > 99) end_sim(1);
      end while (!(w ? bvalid : rvalid));
      d = w ? 0 : rdata;
      r = w ? bresp : rresp;
      {bready, rready} <= 2'h0;
   endtask
   task automatic rst;
      aresetn <= 0;
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      repeat (12) @(posedge aclk);
   endtask
   task automatic dbg(logic [15:0] ad, logic [17:0] e);
      @(posedge aclk);
      {dbg_rd_addr, dbg_rd_req} <= {ad, 1'b1};
      @(posedge aclk);
      dbg_rd_req <= 0;
      for (n = 0; n < 9 && !dbg_rd_valid && !dbg_rd_denied; n++) @(posedge aclk);
      chk({dbg_rd_denied, dbg_rd_valid, dbg_rd_valid ? dbg_rd_data : 16'h0}, e);
   endtask
   // polls until a flag shows; a second read must find the flags gone
   task automatic cmd(logic [7:0] c, e);
      ax(1, `COMMAND_ADDR, c);
      for (int k = 0; k < 20000 && d[1:0] == 0; k++) begin
         ax(0, `STATUS_ADDR, 0);
         if (k == 0 && c == 8'h02 && e == 8'h29) chk(d, 32'h24);
      end
      chk(d, e);
      ax(0, `STATUS_ADDR, 0);
      chk(d, 32'h20);
   endtask
   task automatic sv(logic [31:0] k, pv, logic [7:0] e);
      ax(1, `PERSIST_ADDR, pv);
      ax(1, `MODE_ADDR, 32'h48);
      ax(1, `ADDRESS_ADDR, k[31:16]);
      ax(1, `DATA_ADDR, k[15:0]);
      cmd(8'h0c, e);
   endtask
   initial begin
      n = $urandom(32'hef45);
      rst();
      chk(download_mode, 1);
      ax(1, 32'hffff_f8f0, 0);
      chk(r, 2'h2);
      ax(0, 32'hffff_f8f0, 0);
      chk(r, 2'h2);
      chk(d, 0);
      ax(0, `VOLATILE_ADDR, 0);
      chk(r, 2'h0);
      chk(d, 32'hffff_ffff);
      p = $urandom_range(29, 0);
      a = p * 2048 + 2 * $urandom_range(1023, 0);
      v = $urandom;
      ax(1, `VOLATILE_ADDR, 32'h7fff_ffff);
      dbg(a, 18'h2_0000);
      ax(1, `VOLATILE_ADDR, ~(32'h1 << p));
      ax(1, `MODE_ADDR, 32'h18);
      ax(1, `ADDRESS_ADDR, a);
      ax(1, `DATA_ADDR, v);
      cmd(8'h02, 8'h2a);
      ax(1, `ADDRESS_ADDR, a + 2048);
      cmd(8'h02, 8'h29);
      dbg(a, 18'h1_ffff);
      dbg(a + 2048, {2'h1, v});
      ax(1, `MODE_ADDR, 32'h8);
      for (int c = 7; c < 16; c++) cmd(8'(c), c == 15 ? 8'h21 : 8'h22);
      sv(32'h1234_5678, 32'h7fff_ffff, 8'h21);
      chk(read_protect_active, 0);
      sv(32'h1234_5678, 32'h7fff_ffff, 8'h22);
      rst();
      chk(read_protect_active, 1);
      sv(32'h1111_5678, 32'hffff_ffff, 8'h22);
      cmd(8'h06, 8'h21);
      sv(32'hdead_dead, 32'h7fff_ffff, 8'h21);
      rst();
      sv(32'hdead_dead, 32'hffff_ffff, 8'h22);
      cmd(8'h06, 8'h21);
      dbg(a + 2048, 18'h1_ffff);
      end_sim(0);
   end
endmodule
